// >>> cml_boot_loader.sv
// Configuration mode capture and boot stream loader
`timescale 1ns/10ps
module cml_boot_loader (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [3:0]         boot_source_select,
    input  wire logic               por_enable,
    input  wire logic               supplies_stable,
    input  wire logic [1:0]         lane_width,
    input  wire logic [23:0]        seq_start_addr,
    input  wire logic               pll_locked,
    input  wire logic               pll_switch,
    input  wire logic               cfg_error,
    input  wire logic               cfg_complete,
    input  wire logic               bank_user,
    input  wire logic               tap_byte_valid,
    input  wire logic [7:0]         tap_byte_data,
    output logic                    tap_byte_ready,
    input  wire logic               user_byte_valid,
    input  wire logic [7:0]         user_byte_data,
    output logic                    user_byte_ready,
    output logic                    cfg_byte_valid,
    input  wire logic               cfg_byte_ready,
    output cml_pkg::cml_byte_s      cfg_byte,
    input  wire logic               spi_cs_n_in,
    output logic                    spi_cs_n_out,
    output logic                    spi_cs_n_oe,
    input  wire logic               spi_sclk_in,
    output logic                    spi_sclk_out,
    output logic                    spi_sclk_oe,
    input  wire logic               boot_spi_io0_in,
    output logic                    boot_spi_io0_out,
    output logic                    boot_spi_io0_oe,
    input  wire logic               boot_spi_io1,
    input  wire logic               boot_spi_io2,
    input  wire logic               boot_spi_io3,
    output logic                    cfg_done,
    output logic                    cfg_done_oe,
    input  wire logic               cfg_failed_n_in,
    output logic                    cfg_failed_n_out,
    output logic                    cfg_failed_n_oe,
    output logic                    chain_data_forward,
    output logic [3:0]              mode_captured,
    output logic                    passive_overrun,
    output logic                    bus_failed_seen
);
    import cml_pkg::*;

    localparam int SYNC_W = 13;

    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic [3:0]        mode_pins;
    logic              cs_s;
    logic              sclk_s;
    logic [3:0]        io_s;
    logic              fail_s;
    logic              lock_s;
    logic              stable_s;
    logic              sclk_prev_reg;

    logic [1:0]        cap_cnt_reg;
    logic              captured;
    logic [3:0]        mode_reg;
    logic              run;
    logic              active;
    logic              passive;
    logic              cpol;
    logic              cpha;

    cml_state_e        state_reg;
    logic [3:0]        half_cnt_reg;
    logic              ph_reg;
    logic              tick;
    logic              lead;
    logic              trail;
    logic              sample;
    logic              launch;
    logic [39:0]       cmd_sr_reg;
    logic              mosi_reg;
    logic [5:0]        bit_cnt_reg;
    logic [5:0]        cmd_len;
    logic [7:0]        rx_sr_reg;
    logic [3:0]        rx_cnt_reg;
    logic [7:0]        rx_next;
    logic [3:0]        rx_step;
    logic [1:0]        retry_reg;
    logic [3:0]        pulse_cnt_reg;
    logic              done_reg;
    logic              fail_reg;
    logic              fwd_reg;
    logic              overrun_reg;

    logic              push_valid_reg;
    logic [7:0]        push_data_reg;
    logic              spi_take;
    logic              buf_in_valid;
    logic              buf_in_ready;
    cml_byte_s         buf_in;
    logic              p_lead;
    logic              p_byte;
    logic [3:0]        p_cnt_reg;
    logic [7:0]        p_sr_reg;

    // Two-flop synchroniser for every pin input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {boot_source_select, spi_cs_n_in, spi_sclk_in, boot_spi_io3, boot_spi_io2,
                         boot_spi_io1, boot_spi_io0_in, cfg_failed_n_in, pll_locked, supplies_stable};
            sync_reg <= meta_reg;
        end
    end

    assign mode_pins = sync_reg[12:9];
    assign cs_s      = sync_reg[8];
    assign sclk_s    = sync_reg[7];
    assign io_s      = sync_reg[6:3];
    assign fail_s    = sync_reg[2];
    assign lock_s    = sync_reg[1];
    assign stable_s  = sync_reg[0];

    // Mode capture a fixed time after reset release, once the pins have settled
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_reg <= 2'h0;
            mode_reg    <= MODE_TEST;
        end else begin
            if (!captured) cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == 2'h2) mode_reg <= mode_pins;
        end
    end

    assign captured = cap_cnt_reg == 2'h3;
    assign run      = captured && (!por_enable || stable_s);
    assign active   = captured && cml_is_active(mode_reg);
    assign passive  = captured && cml_is_passive(mode_reg);
    assign cpol     = mode_reg[CPOL_BIT];
    assign cpha     = mode_reg[CPHA_BIT];
    assign mode_captured = mode_reg;

    // Internal serial clock divider, faster once the reference PLL is locked and pll_switch is set
    assign tick    = (half_cnt_reg == 4'h0) && !push_valid_reg;
    assign lead    = tick && !ph_reg;
    assign trail   = tick && ph_reg;
    assign sample  = cpha ? trail : lead;
    assign launch  = cpha ? lead : trail;
    assign cmd_len = (lane_width == LANE_1) ? CMD_ADDR_BITS : CMD_ADDR_BITS + DUMMY_BITS;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt_reg <= 4'h0;
            ph_reg       <= 1'b0;
        end else if (state_reg != ST_CMD && state_reg != ST_READ) begin
            half_cnt_reg <= 4'(HALF_CYC - 1);
            ph_reg       <= 1'b0;
        end else if (!push_valid_reg) begin
            if (half_cnt_reg == 4'h0) begin
                half_cnt_reg <= (pll_switch && lock_s) ? 4'(FAST_HALF_CYC - 1) : 4'(HALF_CYC - 1);
                ph_reg       <= ~ph_reg;
            end else begin
                half_cnt_reg <= half_cnt_reg - 4'h1;
            end
        end
    end

    function automatic logic [7:0] read_cmd(input logic [1:0] w);
        case (w)
            LANE_2:  return CMD_READ_2;
            LANE_4:  return CMD_READ_4;
            default: return CMD_READ_1;
        endcase
    endfunction

    // Lane-width dependent byte assembly
    always_comb begin
        case (lane_width)
            LANE_2: begin
                rx_next = {rx_sr_reg[5:0], io_s[1], io_s[0]};
                rx_step = 4'h2;
            end
            LANE_4: begin
                rx_next = {rx_sr_reg[3:0], io_s[3], io_s[2], io_s[1], io_s[0]};
                rx_step = 4'h4;
            end
            default: begin
                rx_next = {rx_sr_reg[6:0], io_s[1]};
                rx_step = 4'h1;
            end
        endcase
    end

    // Active loader sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= ST_WAIT;
            cmd_sr_reg    <= '0;
            mosi_reg      <= 1'b0;
            bit_cnt_reg   <= 6'h0;
            rx_cnt_reg    <= 4'h0;
            rx_sr_reg     <= 8'h0;
            retry_reg     <= 2'h0;
            pulse_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                ST_WAIT: begin
                    if (active && run) begin
                        state_reg   <= ST_CMD;
                        cmd_sr_reg  <= {read_cmd(lane_width), 24'h000000, 8'h00};
                        mosi_reg    <= 1'(read_cmd(lane_width) >> 7);
                        bit_cnt_reg <= 6'h0;
                    end
                end
                ST_CMD: begin
                    if (launch) begin
                        mosi_reg   <= cpha ? cmd_sr_reg[39] : cmd_sr_reg[38];
                        cmd_sr_reg <= cmd_sr_reg << (cpha ? 0 : 1);
                    end
                    if (sample) begin
                        if (cpha) cmd_sr_reg <= cmd_sr_reg << 1;
                        bit_cnt_reg <= bit_cnt_reg + 6'h1;
                        if (bit_cnt_reg == cmd_len - 6'h1) begin
                            state_reg  <= ST_READ;
                            rx_cnt_reg <= 4'h0;
                        end
                    end
                end
                ST_READ: begin
                    if (sample) begin
                        rx_sr_reg  <= rx_next;
                        rx_cnt_reg <= (rx_cnt_reg + rx_step == 4'h8) ? 4'h0 : rx_cnt_reg + rx_step;
                    end
                end
                ST_PULSE: begin
                    pulse_cnt_reg <= pulse_cnt_reg - 4'h1;
                    if (pulse_cnt_reg == 4'h1) begin
                        state_reg   <= ST_CMD;
                        cmd_sr_reg  <= {read_cmd(lane_width), seq_start_addr, 8'h00};
                        mosi_reg    <= 1'(read_cmd(lane_width) >> 7);
                        bit_cnt_reg <= 6'h0;
                    end
                end
                default: ;
            endcase
            if ((state_reg == ST_CMD || state_reg == ST_READ) && cfg_complete) begin
                state_reg <= ST_DONE;
            end else if ((state_reg == ST_CMD || state_reg == ST_READ) && cfg_error) begin
                if (retry_reg == MAX_RETRIES) begin
                    state_reg <= ST_FAIL;
                end else begin
                    retry_reg     <= retry_reg + 2'h1;
                    state_reg     <= ST_PULSE;
                    pulse_cnt_reg <= 4'(FAIL_PULSE_CYC);
                end
            end else if (state_reg == ST_WAIT && captured && !active && run) begin
                if (cfg_complete) state_reg <= ST_DONE;
                else if (cfg_error) state_reg <= ST_FAIL;
            end
        end
    end

    // Passive receiver edge tracking on the host clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) sclk_prev_reg <= 1'b0;
        else sclk_prev_reg <= sclk_s;
    end

    assign p_lead = passive && !cs_s && (sclk_s != sclk_prev_reg) && (sclk_s == (cpha ? cpol : !cpol));
    assign p_byte = p_lead && (p_cnt_reg == 4'h7);

    // Byte hand-off from the SPI side; active mode stalls, passive may overrun
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            push_valid_reg <= 1'b0;
            push_data_reg  <= 8'h0;
            overrun_reg    <= 1'b0;
        end else begin
            if (spi_take) push_valid_reg <= 1'b0;
            if (state_reg == ST_READ && sample && (rx_cnt_reg + rx_step == 4'h8)) begin
                push_valid_reg <= 1'b1;
                push_data_reg  <= rx_next;
            end else if (p_byte) begin
                if (push_valid_reg && !spi_take) overrun_reg <= 1'b1;
                push_valid_reg <= 1'b1;
                push_data_reg  <= {p_sr_reg[6:0], io_s[0]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p_cnt_reg <= 4'h0;
            p_sr_reg  <= 8'h0;
        end else if (!passive || cs_s) begin
            p_cnt_reg <= 4'h0;
        end else if (p_lead) begin
            p_sr_reg  <= {p_sr_reg[6:0], io_s[0]};
            p_cnt_reg <= (p_cnt_reg == 4'h7) ? 4'h0 : p_cnt_reg + 4'h1;
        end
    end

    // Source arbitration: test port, then user logic, then SPI
    assign tap_byte_ready  = buf_in_ready;
    assign user_byte_ready = buf_in_ready && !tap_byte_valid;
    assign spi_take        = push_valid_reg && buf_in_ready && !tap_byte_valid && !user_byte_valid;
    assign buf_in_valid    = tap_byte_valid || user_byte_valid || push_valid_reg;

    always_comb begin
        if (tap_byte_valid) buf_in = '{data: tap_byte_data, src: SRC_TAP};
        else if (user_byte_valid) buf_in = '{data: user_byte_data, src: SRC_USER};
        else buf_in = '{data: push_data_reg, src: SRC_SPI};
    end

    cml_buf u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (cfg_byte_valid),
        .out_ready (cfg_byte_ready),
        .out_data  (cfg_byte)
    );

    // Status flags and chain forward
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            fwd_reg  <= 1'b0;
        end else begin
            done_reg <= state_reg == ST_DONE || state_reg == ST_FAIL;
            fail_reg <= state_reg == ST_PULSE || state_reg == ST_FAIL;
            fwd_reg  <= active && lane_width == LANE_1 && state_reg == ST_DONE && io_s[1];
        end
    end

    assign cfg_done         = done_reg;
    assign cfg_done_oe      = !bank_user;
    assign cfg_failed_n_out = 1'b0;
    assign cfg_failed_n_oe  = fail_reg;
    assign bus_failed_seen  = !fail_s && !fail_reg;
    assign chain_data_forward = fwd_reg;
    assign passive_overrun  = overrun_reg;

    // Shared pins, driven whenever the captured mode is active; io0 is released in ST_READ for two- and four-lane reads
    assign spi_cs_n_oe      = active;
    assign spi_sclk_oe      = active;
    assign spi_cs_n_out     = !(state_reg == ST_CMD || state_reg == ST_READ);
    assign spi_sclk_out     = cpol ^ ph_reg;
    assign boot_spi_io0_oe  = active && !(state_reg == ST_READ && lane_width != LANE_1);
    assign boot_spi_io0_out = mosi_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence pulse_run_s;
        (state_reg == ST_PULSE && cfg_failed_n_oe)[*8];
    endsequence

    sequence enter_pulse_s;
        $rose(state_reg == ST_PULSE);
    endsequence

    mode_hold_a: assert property (captured && $past(captured) |-> $stable(mode_reg))
        else $error("captured mode changed");
    pins_input_a: assert property (!active |-> !spi_cs_n_oe && !spi_sclk_oe && !boot_spi_io0_oe)
        else $error("pin driven outside active mode");
    auto_start_a: assert property (state_reg == ST_WAIT && active && run |=> state_reg == ST_CMD)
        else $error("active load did not start");
    sclk_idle_a: assert property (state_reg == ST_WAIT |-> spi_sclk_out == cpol)
        else $error("serial clock not idle at polarity");
    retry_pulse_a: assert property (enter_pulse_s |=> pulse_run_s ##[1:3] state_reg == ST_CMD)
        else $error("failure pulse or retry wrong");
    fail_state_a: assert property (state_reg == ST_FAIL |=> cfg_done && cfg_failed_n_oe)
        else $error("failed status not shown");
    done_state_a: assert property ((state_reg == ST_CMD || state_reg == ST_READ) && cfg_complete |=> ##1 cfg_done && !cfg_failed_n_oe)
        else $error("success status not shown");
    fwd_single_a: assert property (chain_data_forward |-> lane_width == LANE_1 && active)
        else $error("forward outside single-line mode");
    tap_first_a: assert property (tap_byte_valid |-> buf_in.src == SRC_TAP && buf_in_valid)
        else $error("test port byte not preferred");
endmodule // cml_boot_loader

// >>> cml_buf.sv
// Boot loader constants, types and the two-entry byte buffer
//
// Overview of operation
// - Accept boot bytes from own flash read, external SPI host, test port, user logic.
// - Capture the four mode pins a fixed time after reset rises; that value picks the mode.
// - Codes 0-3 active SPI, 4-7 passive SPI, bit1 CPOL, bit0 CPHA; 12 test port.
// - Chip select, clock and io0 drive only in active mode; inputs otherwise.
// - Active and passive modes share one set of SPI pins.
// - Flash read over one, two or four data lines; extra lines only when wider.
// - In active mode, reset release starts the flash read without outside help.
// - Active mode serial clock comes from the internal clock, no reference needed.
// - A locked external reference lets the stream switch to a faster serial clock.
// - Active mode error gives a short low failure pulse and re-reads the sequence, three times at most; a fourth error fails.
// - In passive mode the host owns the bus; the device only follows the stream.
// - Done low/fail high busy, done high/fail high ok, done high/fail low failed.
// - Done is driven low and failure released while reset is held.
// - Once the pin bank turns to user function, done may no longer be visible.
// - A forward output chains devices from one flash, single-line mode only.
// - Reset is active low; with power-on reset enabled, supplies must also be stable.
// - Test port loading works whatever the mode pins hold.
package cml_pkg;
    localparam int CLK_PERIOD_NS    = 4;
    localparam int SCLK_HALF_NS     = 20;
    localparam int SCLK_FAST_HALF_NS = 12;
    localparam int HALF_CYC         = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_HALF_CYC    = (SCLK_FAST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAIL_PULSE_NS    = 40;
    localparam int FAIL_PULSE_CYC   = FAIL_PULSE_NS / CLK_PERIOD_NS;
    localparam logic [3:0] MODE_ACTIVE_MAX  = 4'h3;
    localparam logic [3:0] MODE_PASSIVE_MAX = 4'h7;
    localparam logic [3:0] MODE_TEST        = 4'hc;
    localparam int CPOL_BIT = 1;
    localparam int CPHA_BIT = 0;
    localparam logic [7:0] CMD_READ_1 = 8'h03;
    localparam logic [7:0] CMD_READ_2 = 8'h3b;
    localparam logic [7:0] CMD_READ_4 = 8'h6b;
    localparam logic [5:0] CMD_ADDR_BITS = 6'h20;
    localparam logic [5:0] DUMMY_BITS    = 6'h08;
    localparam logic [1:0] MAX_RETRIES   = 2'h3;
    localparam logic [1:0] LANE_1 = 2'h0;
    localparam logic [1:0] LANE_2 = 2'h1;
    localparam logic [1:0] LANE_4 = 2'h2;
    localparam logic [1:0] SRC_TAP = 2'h0;
    localparam logic [1:0] SRC_USER = 2'h1;
    localparam logic [1:0] SRC_SPI = 2'h2;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic [7:0] data;
        logic [1:0] src;
    } cml_byte_s;

    typedef enum logic [5:0] {
        ST_WAIT  = 6'h01,
        ST_CMD   = 6'h02,
        ST_READ  = 6'h04,
        ST_PULSE = 6'h08,
        ST_DONE  = 6'h10,
        ST_FAIL  = 6'h20
    } cml_state_e;

    function automatic logic cml_is_active(input logic [3:0] m);
        return m <= MODE_ACTIVE_MAX;
    endfunction

    function automatic logic cml_is_passive(input logic [3:0] m);
        return (m > MODE_ACTIVE_MAX) && (m <= MODE_PASSIVE_MAX);
    endfunction
endpackage

`timescale 1ns/10ps
module cml_buf (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire cml_pkg::cml_byte_s in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output cml_pkg::cml_byte_s      out_data
);
    import cml_pkg::*;

    cml_byte_s mem_reg [BUF_DEPTH];
    logic      wr_ptr_reg;
    logic      rd_ptr_reg;
    logic [1:0] count_reg;
    logic      push;
    logic      pop;

    assign in_ready  = count_reg != 2'(BUF_DEPTH);
    assign out_valid = count_reg != 2'h0;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) wr_ptr_reg <= ~wr_ptr_reg;
            if (pop) rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    no_overflow_a: assert property (count_reg == 2'(BUF_DEPTH) |-> !in_ready)
        else $error("buffer accepts while full");
endmodule // cml_buf

// >>> cml_flash_model.sv
// Serial flash that answers a single-lane read
`timescale 1ns/10ps
module cml_flash_model (
    input  wire logic cs_n,
    input  wire logic sclk,
    output logic      so
);
    int bit_cnt;
    initial begin
        so = 1'b0;
        bit_cnt = 0;
    end
    always @(negedge cs_n) bit_cnt = 0;
    always @(posedge sclk) if (!cs_n) bit_cnt++;
    // Command and address take 32 clocks, then bytes MSB first
    always @(negedge sclk) begin
        if (!cs_n && bit_cnt >= 32) begin
            so <= 8'(8'ha5 + (bit_cnt - 32) / 8) >> (7 - (bit_cnt - 32) % 8);
        end
    end
    // Released line shows no stale value
    always @(posedge cs_n) so <= ~so;
endmodule // cml_flash_model

// >>> cml_boot_loader_test.sv
// Self-checking bench for the boot loader
`timescale 1ns/10ps
module cml_boot_loader_test;
    import cml_pkg::*;
    logic clk = 0, rst_n = 0, por_enable = 0, supplies_stable = 1, pll_locked = 0, pll_switch = 0;
    logic [3:0] boot_source_select = 0, mode_captured;
    logic [1:0] lane_width = LANE_1;
    logic [23:0] seq_start_addr = 0;
    logic cfg_error = 0, cfg_complete = 0, bank_user = 0, tap_byte_valid = 0, user_byte_valid = 0;
    logic [7:0] tap_byte_data = 0, user_byte_data = 0;
    logic cfg_byte_ready = 1, boot_spi_io2 = 1, boot_spi_io3 = 1, boot_spi_io1;
    logic tap_byte_ready, user_byte_ready, cfg_byte_valid, spi_cs_n_out, spi_cs_n_oe, spi_sclk_out;
    logic spi_sclk_oe, boot_spi_io0_out, boot_spi_io0_oe, cfg_done, cfg_done_oe, cfg_failed_n_out;
    logic cfg_failed_n_oe, chain_data_forward, passive_overrun, bus_failed_seen;
    cml_byte_s cfg_byte;
    logic host_cs_n = 1, host_sclk = 0, host_io0 = 1;
    logic [1:0] pm;
    logic [7:0] pb [4];
    wire spi_cs_n_in = spi_cs_n_oe ? spi_cs_n_out : host_cs_n;
    wire spi_sclk_in = spi_sclk_oe ? spi_sclk_out : host_sclk;
    wire boot_spi_io0_in = boot_spi_io0_oe ? boot_spi_io0_out : host_io0;
    wire cfg_failed_n_in = !cfg_failed_n_oe;
    int fails = 0, comparisons = 0, seed = 32'h6caa, i;
    cml_boot_loader dut_u (.*);
    cml_flash_model flash_u (.cs_n(spi_cs_n_in), .sclk(spi_sclk_in), .so(boot_spi_io1));
    always #2 clk = ~clk;
    task conclude;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string n, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task boot(input logic [3:0] m);
        rst_n = 0;
        boot_source_select = m;
        seq_start_addr = 24'($random(seed));
        step(8);
        chk("done_in_reset", 0, {cfg_done, cfg_failed_n_oe, spi_cs_n_oe});
        rst_n = 1;
        step(4);
        chk("mode", 10'(m), 10'(mode_captured));
        chk("cs_oe", 10'(m <= MODE_ACTIVE_MAX), 10'(spi_cs_n_oe));
    endtask
    task wait_byte(input logic [9:0] e);
        for (i = 0; i < 3000 && cfg_byte_valid !== 1'b1; i++) step(1);
        if (i == 3000) begin
            fails++;
            conclude;
        end
        chk("cfg_byte", e, cfg_byte);
        step(1);
    endtask
    task pulse_status(input bit err, input logic [1:0] e);
        {cfg_error, cfg_complete} = {err, !err};
        step(1);
        {cfg_error, cfg_complete} = 0;
        step(2);
        chk("status", 10'(e), {cfg_done, cfg_failed_n_oe});
    endtask
    // External host shifts one byte MSB first in SPI mode m
    task host_byte(input logic [7:0] b, input logic [1:0] m);
        host_sclk = m[1];
        step(2);
        host_cs_n = 0;
        for (int k = 7; k >= 0; k--) begin
            if (!m[0]) host_io0 = b[k];
            step(4);
            host_sclk = !m[1];
            if (m[0]) host_io0 = b[k];
            step(4);
            host_sclk = m[1];
        end
        step(4);
        host_cs_n = 1;
    endtask
    initial begin
        step(1);
        boot(($random(seed) & 1) ? MODE_TEST : 4'h4 | 4'($random(seed) & 3));
        cfg_byte_ready = 0;
        tap_byte_data = 8'($random(seed));
        user_byte_data = 8'($random(seed));
        {tap_byte_valid, user_byte_valid} = 2'b11;
        #0.5 chk("user_ready", 0, 10'(user_byte_ready));
        step(1);
        tap_byte_valid = 0;
        step(1);
        user_byte_valid = 0;
        tap_byte_valid = 1;
        #0.5 chk("tap_full", 0, 10'(tap_byte_ready));
        step(1);
        tap_byte_valid = 0;
        cfg_byte_ready = 1;
        wait_byte({tap_byte_data, SRC_TAP});
        wait_byte({user_byte_data, SRC_USER});
        pulse_status(0, 2'b10);
        pm = 2'($random(seed));
        boot(4'h4 | 4'(pm));
        cfg_byte_ready = 0;
        for (int k = 0; k < 4; k++) begin
            pb[k] = 8'($random(seed));
            host_byte(pb[k], pm);
        end
        chk("overrun", 1, 10'(passive_overrun));
        cfg_byte_ready = 1;
        wait_byte({pb[0], SRC_SPI});
        wait_byte({pb[1], SRC_SPI});
        wait_byte({pb[3], SRC_SPI});
        boot(4'h0);
        wait_byte({8'ha5, SRC_SPI});
        chk("busy", 0, {cfg_done, cfg_failed_n_oe});
        cfg_error = 1;
        step(1);
        cfg_error = 0;
        for (i = 0; i < 20 && cfg_failed_n_oe !== 1'b1; i++) step(1);
        if (i == 20) begin
            fails++;
            conclude;
        end
        for (i = 0; i < 40 && cfg_failed_n_oe === 1'b1; i++) step(1);
        chk("fail_pulse", 10'(FAIL_PULSE_CYC), 10'(i));
        chk("reread_cs", 10'b10, {spi_cs_n_oe, spi_cs_n_out});
        pulse_status(0, 2'b10);
        bank_user = 1;
        step(2);
        chk("done_oe", 0, 10'(cfg_done_oe));
        chk("forward", 10'(boot_spi_io1), 10'(chain_data_forward));
        boot(4'h0);
        for (int k = 0; k < 4; k++) begin
            pulse_status(1, k < 3 ? 2'b01 : 2'b11);
            step(10);
        end
        conclude;
    end
endmodule // cml_boot_loader_test
